// *** include/pfm_pkg.sv ***
// Purpose: constants and types for the pin function and event source mux
// Assumes: 32-bit APB data, byte offsets within the block
// Notes: two ports of sixteen pins, sixteen event lines
package pfm_pkg;
  localparam int PFM_PINS = 16;
  localparam int PFM_LINES = 16;
  localparam int PFM_FW = 4;
  localparam logic [11:0] PFM_OFF_ESS_LO = 12'h000;
  localparam logic [11:0] PFM_OFF_ESS_HI = 12'h004;
  localparam logic [11:0] PFM_OFF_PA_LO = 12'h020;
  localparam logic [11:0] PFM_OFF_PA_HI = 12'h024;
  localparam logic [11:0] PFM_OFF_PB_LO = 12'h028;
  localparam logic [11:0] PFM_OFF_PB_HI = 12'h02C;
  localparam logic [31:0] PFM_REG_RESET = 32'h0000_0000;
  localparam logic [3:0] PFM_FUNC_DEFAULT = 4'h0;
  localparam logic [3:0] PFM_SRC_PORT_A = 4'h0;
  localparam logic [3:0] PFM_SRC_PORT_B = 4'h1;

  typedef struct packed {
    logic sel;
    logic en;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pfm_apb_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
  } pfm_apb_rsp_s;
endpackage

// *** rtl/pfm_mux.sv ***
// Purpose: pin function selection and event line source selection
// Assumes: lock bits come from the port lock register, held until reset
// Notes: registers reached over APB, zero wait states
`timescale 1ns/100ps
module pfm_mux
  import pfm_pkg::*;
#(
  parameter logic [15:0] PORT_A_PRESENT = 16'hFFFF,
  parameter logic [15:0] PORT_B_PRESENT = 16'hFFFF,
  parameter logic [15:0] FUNC_IMPLEMENTED = 16'hFFFF
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] port_a_lock_i,
  input wire logic [15:0] port_b_lock_i,
  input wire logic [15:0] port_a_in_i,
  input wire logic [15:0] port_b_in_i,
  output logic [63:0] port_a_func_o,
  output logic [63:0] port_b_func_o,
  output logic [15:0] event_line_o
);

  ////////////////////////////////////////////////////////////////////////
  // register bank
  pfm_apb_req_s req;
  logic [31:0] ess_lo_r, ess_hi_r, pa_lo_r, pa_hi_r, pb_lo_r, pb_hi_r;
  logic [31:0] ess_lo_nxt, ess_hi_nxt, pa_lo_nxt, pa_hi_nxt, pb_lo_nxt, pb_hi_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr_setup;

  assign req = '{sel: psel_i, en: penable_i, write: pwrite_i, addr: paddr_i,
                 wdata: pwdata_i};

  // lock applied per 4-bit field; key and write-once stay with the lock owner
  function automatic logic [31:0] lock_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [7:0] lk);
    logic [31:0] r;
    r = new_v;
    for (int i = 0; i < 8; i++) begin
      if (lk[i]) begin
        r[i*4 +: 4] = old_v[i*4 +: 4];
      end
    end
    return r;
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    return (a == PFM_OFF_ESS_LO) || (a == PFM_OFF_ESS_HI) || (a == PFM_OFF_PA_LO) ||
           (a == PFM_OFF_PA_HI) || (a == PFM_OFF_PB_LO) || (a == PFM_OFF_PB_HI);
  endfunction

  // act in setup phase so the access phase completes with pready high
  assign wr_setup = req.sel && !req.en && req.write;

  always_comb begin
    ess_lo_nxt = ess_lo_r;
    ess_hi_nxt = ess_hi_r;
    pa_lo_nxt = pa_lo_r;
    pa_hi_nxt = pa_hi_r;
    pb_lo_nxt = pb_lo_r;
    pb_hi_nxt = pb_hi_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (req.sel && !req.en) begin
      pslverr_nxt = !addr_known(req.addr);
      unique case (req.addr)
        PFM_OFF_ESS_LO: prdata_nxt = ess_lo_r;
        PFM_OFF_ESS_HI: prdata_nxt = ess_hi_r;
        PFM_OFF_PA_LO: prdata_nxt = pa_lo_r;
        PFM_OFF_PA_HI: prdata_nxt = pa_hi_r;
        PFM_OFF_PB_LO: prdata_nxt = pb_lo_r;
        PFM_OFF_PB_HI: prdata_nxt = pb_hi_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
      if (req.write) begin
        prdata_nxt = 32'h0000_0000;
      end
    end
    if (wr_setup) begin
      unique case (req.addr)
        PFM_OFF_ESS_LO: ess_lo_nxt = req.wdata;
        PFM_OFF_ESS_HI: ess_hi_nxt = req.wdata;
        PFM_OFF_PA_LO: pa_lo_nxt = lock_merge(pa_lo_r, req.wdata, port_a_lock_i[7:0]);
        PFM_OFF_PA_HI: pa_hi_nxt = lock_merge(pa_hi_r, req.wdata, port_a_lock_i[15:8]);
        PFM_OFF_PB_LO: pb_lo_nxt = lock_merge(pb_lo_r, req.wdata, port_b_lock_i[7:0]);
        PFM_OFF_PB_HI: pb_hi_nxt = lock_merge(pb_hi_r, req.wdata, port_b_lock_i[15:8]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ess_lo_r <= PFM_REG_RESET;
      ess_hi_r <= PFM_REG_RESET;
      pa_lo_r <= PFM_REG_RESET;
      pa_hi_r <= PFM_REG_RESET;
      pb_lo_r <= PFM_REG_RESET;
      pb_hi_r <= PFM_REG_RESET;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      ess_lo_r <= ess_lo_nxt;
      ess_hi_r <= ess_hi_nxt;
      pa_lo_r <= pa_lo_nxt;
      pa_hi_r <= pa_hi_nxt;
      pb_lo_r <= pb_lo_nxt;
      pb_hi_r <= pb_hi_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r;
  assign pready_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // pin function and event source decode, registered to the outputs
  logic [63:0] pa_cfg, pb_cfg;
  logic [63:0] pa_func_r, pb_func_r, pa_func_nxt, pb_func_nxt;
  logic [63:0] ess_all;
  logic [15:0] ev_r, ev_nxt;

  assign pa_cfg = {pa_hi_r, pa_lo_r};
  assign pb_cfg = {pb_hi_r, pb_lo_r};
  assign ess_all = {ess_hi_r, ess_lo_r};

  // unimplemented functions fall back to the default mapping
  function automatic logic [3:0] func_pick(input logic [3:0] sel);
    return FUNC_IMPLEMENTED[sel] ? sel : PFM_FUNC_DEFAULT;
  endfunction

  always_comb begin
    pa_func_nxt = '0;
    pb_func_nxt = '0;
    ev_nxt = '0;
    for (int n = 0; n < PFM_PINS; n++) begin
      pa_func_nxt[n*4 +: 4] = func_pick(pa_cfg[n*4 +: 4]);
      pb_func_nxt[n*4 +: 4] = func_pick(pb_cfg[n*4 +: 4]);
    end
    for (int n = 0; n < PFM_LINES; n++) begin
      // reserved codes and absent pins leave the line undriven (low)
      if (ess_all[n*4 +: 4] == PFM_SRC_PORT_A && PORT_A_PRESENT[n]) begin
        ev_nxt[n] = port_a_in_i[n];
      end else if (ess_all[n*4 +: 4] == PFM_SRC_PORT_B && PORT_B_PRESENT[n]) begin
        ev_nxt[n] = port_b_in_i[n];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pa_func_r <= '0;
      pb_func_r <= '0;
      ev_r <= '0;
    end else begin
      pa_func_r <= pa_func_nxt;
      pb_func_r <= pb_func_nxt;
      ev_r <= ev_nxt;
    end
  end

  assign port_a_func_o = pa_func_r;
  assign port_b_func_o = pb_func_r;
  assign event_line_o = ev_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  locked_field_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    port_b_lock_i[0] && $stable(port_b_lock_i) |=> pb_lo_r[3:0] == $past(pb_lo_r[3:0]))
    else $error("locked port b pin 0 field changed");
  unlocked_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_setup && req.addr == PFM_OFF_PA_LO && port_a_lock_i[7:0] == 8'h00
    |=> pa_lo_r == $past(req.wdata))
    else $error("port a low write lost");
  reset_clear_a: assert property (@(posedge clock_i)
    rst_i |=> ess_lo_r == 32'h0000_0000 && ess_hi_r == 32'h0000_0000 &&
      pa_lo_r == 32'h0000_0000 && pa_hi_r == 32'h0000_0000 &&
      pb_lo_r == 32'h0000_0000 && pb_hi_r == 32'h0000_0000)
    else $error("register not cleared by reset");
  func_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
    FUNC_IMPLEMENTED[pa_cfg[7:4]] |=> pa_func_r[7:4] == $past(pa_cfg[7:4]))
    else $error("function select not forwarded");
  func_fallback_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !FUNC_IMPLEMENTED[pa_cfg[47:44]] |=> pa_func_r[47:44] == 4'h0)
    else $error("unimplemented function not defaulted");
  event_src_b_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ess_hi_r[31:28] == 4'h1 && PORT_B_PRESENT[15] |=> ev_r[15] == $past(port_b_in_i[15]))
    else $error("event line 15 not from port b");
  event_reserved_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ess_lo_r[15:12] > 4'h1 |=> !ev_r[3])
    else $error("reserved event source drove line 3");
  unmapped_err_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req.sel && !req.en && req.addr == 12'h010 |=> pslverr_r ##1 !pslverr_r)
    else $error("unmapped access not flagged");

endmodule

// *** tb/pfm_mux_tb_top.sv ***
// Purpose: self-checking bench for the pin function and event source mux
// Assumes: zero wait state APB, registered outputs
// Notes: function 3 and port B pin 0 left out to reach the fallbacks
`timescale 1ns/100ps
`define CHK(nm, e, s) begin \
  samples_checked++; \
  if ((s) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, s); \
  end \
end
module pfm_mux_tb_top;
  import pfm_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; int sel; logic [63:0] e;} pfm_row_s;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  pfm_apb_req_s req = '0;
  pfm_apb_rsp_s rsp;
  logic [63:0] fa, fb, got;
  logic [15:0] ev, pin_a, pin_b, lk_b;
  logic [15:0] pat = 16'h00FF;
  logic [15:0] lk_a = 16'h0000;
  logic lk_wr = 1'b0;
  logic [31:0] lk_word = 32'h0000_0000;
  logic [31:0] rd;
  logic er;
  logic rdy;
  int errors = 0;
  int samples_checked = 0;
  pfm_row_s rows [6] = '{
    '{PFM_OFF_PA_LO, 32'hFEDC_BA98, 0, 64'h0000_0000_FEDC_BA98},
    '{PFM_OFF_PA_HI, 32'h7654_3210, 0, 64'h7654_0210_FEDC_BA98},
    '{PFM_OFF_PB_LO, 32'h1111_1111, 1, 64'h0000_0000_1111_1111},
    '{PFM_OFF_PB_HI, 32'hF000_000F, 1, 64'hF000_000F_1111_1111},
    '{PFM_OFF_ESS_LO, 32'h2222_2101, 2, 64'h0000_0000_0000_0002},
    '{PFM_OFF_ESS_HI, 32'h1111_1111, 2, 64'h0000_0000_0000_FF02}
  };
  always #5 clock_i = ~clock_i;
  pfm_mux #(.FUNC_IMPLEMENTED(16'hFFF7), .PORT_B_PRESENT(16'hFFFE)) uut (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(req.sel), .penable_i(req.en),
    .pwrite_i(req.write), .paddr_i(req.addr), .pwdata_i(req.wdata),
    .prdata_o(rsp.rdata), .pready_o(rsp.ready), .pslverr_o(rsp.err),
    .port_a_lock_i(lk_a), .port_b_lock_i(lk_b), .port_a_in_i(pin_a),
    .port_b_in_i(pin_b), .port_a_func_o(fa), .port_b_func_o(fb), .event_line_o(ev));
  pfm_pad_model pads (
    .clock_i(clock_i), .rst_i(rst_i), .lock_wr_i(lk_wr), .lock_word_i(lk_word),
    .pat_i(pat), .port_a_in_o(pin_a), .port_b_in_o(pin_b), .port_b_lock_o(lk_b));
  ////////////////////////////////////////
  // setup then access; answer taken at the access edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(negedge clock_i);
    req = '{1'b1, 1'b0, wr, a, d};
    @(negedge clock_i);
    req.en = 1'b1;
    @(posedge clock_i);
    rd = rsp.rdata;
    er = rsp.err;
    rdy = rsp.ready;
    @(negedge clock_i);
    req.sel = 1'b0;
    req.en = 1'b0;
  endtask
  task automatic lock_write(input logic [31:0] w);
    @(negedge clock_i);
    lk_wr = 1'b1;
    lk_word = w;
    @(negedge clock_i);
    lk_wr = 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_i);
    errors++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("readback", rows[i].d, rd)
      got = (rows[i].sel == 0) ? fa : (rows[i].sel == 1) ? fb : {48'h0, ev};
      `CHK("mux output", rows[i].e, got)
      `CHK("access ready", 1'b1, rdy)
    end
    $display("table rows done");
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    $display("unmapped test done");
    // wrong key and second write must both be refused by the lock owner
    lock_write(32'h1234_0002);
    lock_write(32'h5FA0_0001);
    lock_write(32'h5FA0_0002);
    lk_a = 16'h8000;
    apb(1'b1, PFM_OFF_PB_LO, 32'h2222_2222);
    apb(1'b0, PFM_OFF_PB_LO, 32'h0000_0000);
    `CHK("locked port b", 32'h2222_2221, rd)
    apb(1'b1, PFM_OFF_PA_HI, 32'h0000_0000);
    apb(1'b0, PFM_OFF_PA_HI, 32'h0000_0000);
    `CHK("locked port a", 32'h7000_0000, rd)
    $display("lock test done");
    @(negedge clock_i);
    rst_i = 1'b1;
    lk_a = 16'h0000;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("reset value", PFM_REG_RESET, rd)
    end
    `CHK("reset outputs", 128'h0, {fa, fb})
    `CHK("reset event source", 16'h00FF, ev)
    $display("reset test done");
    stop_test();
  end
endmodule

// *** tb/pfm_pad_model.sv ***
// Purpose: pads and port lock owner facing the mux
// Assumes: lock taken once with the key, held until reset
// Notes: port B pins show the inverse of the port A pattern
`timescale 1ns/100ps
module pfm_pad_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic lock_wr_i,
  input wire logic [31:0] lock_word_i,
  input wire logic [15:0] pat_i,
  output logic [15:0] port_a_in_o,
  output logic [15:0] port_b_in_o,
  output logic [15:0] port_b_lock_o
);
  logic done_r;
  assign port_a_in_o = pat_i;
  assign port_b_in_o = ~pat_i;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
      port_b_lock_o <= 16'h0000;
    end else if (lock_wr_i && !done_r && lock_word_i[31:16] == 16'h5FA0) begin
      done_r <= 1'b1;
      port_b_lock_o <= lock_word_i[15:0];
    end
  end
endmodule
